// >>> rtl/iop_param_block.v
// Purpose: Parameter storage and decode for analog and universal inputs
// Assumes: Plain register port, read data one cycle after read strobe
// Notes: Address bit 4 selects parameter set one
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "iop_defs.vh"
module iop_param_block (
  input wire CLK_SYS,
  input wire RST,
  input wire [4:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire [3:0] UI_PIN,
  input wire [3:0] AI_WIRE_BREAK,
  input wire AI_CYCLE_DONE,
  output reg [3:0] DIAG_EN,
  output reg [3:0] WBRK_ACTIVE,
  output reg AO_DIAG_EN,
  output reg MOD_DIAG_IRQ_EN,
  output reg [11:0] UI_USE,
  output reg [3:0] UI_HW_IRQ,
  output reg [3:0] UI_FALLING,
  output reg [2:0] UI_COUNT_DOWN,
  output reg [1:0] UI3_GATE,
  output reg UI3_FREQ_MODE,
  output reg UI3_PERIOD_MODE,
  output reg [1:0] SCAN_SEL,
  output reg [8:0] AI_MEAS,
  output reg [11:0] AI_RANGE,
  output reg [2:0] AI_EOC_IRQ,
  output reg IRQ
);
  reg [7:0] diag_q, wbrk_q, mirq_q, scan_q, stat_q, mask_q;
  reg [7:0] ui_q [0:3];
  reg [7:0] ai_q [0:2];
  reg [3:0] pin_s1_q, pin_s2_q, pin_prev_q;
  reg [4:0] tick_q;
  reg tick_en_q;
  reg [7:0] rd_d;
  wire [23:0] period;
  wire period_done;
  wire scan_cont = (scan_q == `IOP_SCAN_CONT);
  wire [3:0] edge_ev;
  wire [7:0] ev;
  integer k;
  // Tick every 0.5 us: 12.5 cycles at 25 MHz, approximated by a 13-cycle divider
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      tick_q <= 5'h00;
      tick_en_q <= 1'b0;
    end else begin
      tick_en_q <= (tick_q == `IOP_TICK_CYC); // RQ15
      tick_q <= (tick_q == `IOP_TICK_CYC) ? 5'h00 : tick_q + 5'h01;
    end
  end
  // Pin synchronisers
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      pin_prev_q <= 4'h0;
    end else begin
      pin_s1_q <= UI_PIN;
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end
  // Register writes, reserved bits dropped
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      diag_q <= `IOP_ZERO8; // RQ17
      wbrk_q <= `IOP_ZERO8;
      mirq_q <= `IOP_ZERO8;
      scan_q <= `IOP_SCAN_16;
      for (k = 0; k < 4; k = k + 1) ui_q[k] <= `IOP_ZERO8; // RQ17
      for (k = 0; k < 3; k = k + 1) ai_q[k] <= `IOP_AI_RESET; // RQ17
    end else if (WR) begin
      case (ADDR)
        `IOP_A_DIAG: diag_q <= WDATA & `IOP_DIAG_MASK;
        `IOP_A_WBRK: wbrk_q <= WDATA & `IOP_WBRK_MASK; // RQ1
        `IOP_A_MIRQ: mirq_q <= WDATA & `IOP_MIRQ_MASK; // RQ2
        `IOP_A_UI0: ui_q[0] <= WDATA & `IOP_UI12_MASK; // RQ16
        `IOP_A_UI1: ui_q[1] <= WDATA & `IOP_UI12_MASK;
        `IOP_A_UI2: ui_q[2] <= WDATA & `IOP_UI_MASK;
        `IOP_A_UI3: ui_q[3] <= WDATA & `IOP_UI3_MASK;
        `IOP_A_SCAN: scan_q <= WDATA; // RQ11
        `IOP_A_AI0: ai_q[0] <= WDATA & `IOP_AI_MASK; // RQ12
        `IOP_A_AI1: ai_q[1] <= WDATA & `IOP_AI_MASK;
        `IOP_A_AI2: ai_q[2] <= WDATA & `IOP_AI_MASK;
        default: diag_q <= diag_q; // RQ16
      endcase
    end
  end
  // Decode of universal inputs
  reg [2:0] use_dec [0:3];
  reg [3:0] wbrk_d, hw_d, fall_d;
  reg [2:0] dir_d;
  reg [1:0] gate_d, scan_sel_d;
  reg [8:0] meas_d;
  reg [11:0] rng_d;
  reg [2:0] eoc_d;
  integer i;
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      use_dec[i] = ui_q[i][2:0];
      if (i < 2 && use_dec[i] > `IOP_USE_CI) use_dec[i] = `IOP_USE_DI; // RQ3
      if (i == 2 && use_dec[i] > `IOP_USE_PER) use_dec[i] = `IOP_USE_DI; // RQ4
      if (i == 3 && use_dec[i] > `IOP_USE_IRQ) use_dec[i] = `IOP_USE_DI; // RQ5
      hw_d[i] = (use_dec[i] == `IOP_USE_IRQ) |
        ((use_dec[i] == `IOP_USE_CI) & ui_q[i][3]); // RQ6
      if (i == 2)
        fall_d[i] = ((use_dec[i] == `IOP_USE_IRQ) | (use_dec[i] == `IOP_USE_CI))
          & ui_q[i][4]; // RQ8
      else
        fall_d[i] = (use_dec[i] != `IOP_USE_DI) & ui_q[i][4]; // RQ7
    end
    for (i = 0; i < 3; i = i + 1)
      dir_d[i] = (use_dec[i] == `IOP_USE_CI) & ui_q[i][5]; // RQ9
    gate_d = `IOP_GATE_OFF;
    if (use_dec[2] == `IOP_USE_FC && ui_q[2][7:6] <= `IOP_GATE_10)
      gate_d = ui_q[2][7:6]; // RQ10
    case (scan_q)
      `IOP_SCAN_16: scan_sel_d = 2'h0;
      `IOP_SCAN_CONT: scan_sel_d = 2'h1;
      `IOP_SCAN_3, `IOP_SCAN_35, `IOP_SCAN_4: scan_sel_d = 2'h2;
      default: scan_sel_d = 2'h0; // RQ16
    endcase
    for (i = 0; i < 3; i = i + 1) begin
      meas_d[i*3 +: 3] = {1'b0, ai_q[i][1:0]};
      rng_d[i*4 +: 4] = ai_q[i][7:4];
      if (ai_q[i][1:0] == `IOP_TYPE_V && ai_q[i][7:4] != `IOP_RNG_PM10)
        rng_d[i*4 +: 4] = `IOP_RNG_OFF; // RQ12
      if (ai_q[i][1:0] == `IOP_TYPE_I && ai_q[i][7:4] != `IOP_RNG_420 &&
          ai_q[i][7:4] != `IOP_RNG_PM20)
        rng_d[i*4 +: 4] = `IOP_RNG_OFF; // RQ16
      if (ai_q[i][1:0] != `IOP_TYPE_V && ai_q[i][1:0] != `IOP_TYPE_I) begin
        meas_d[i*3 +: 3] = 3'h0;
        rng_d[i*4 +: 4] = `IOP_RNG_OFF;
      end
      eoc_d[i] = ai_q[i][2] & ~scan_cont; // RQ13
    end
    for (i = 0; i < 3; i = i + 1)
      wbrk_d[i] = wbrk_q[i] & (rng_d[i*4 +: 4] == `IOP_RNG_420); // RQ1
    wbrk_d[3] = 1'b0;
  end
  iop_period_counter u_period (
    .clk(CLK_SYS),
    .rst(RST),
    .enable(use_dec[2] == `IOP_USE_PER),
    .tick(tick_en_q),
    .level(pin_s2_q[2]),
    .period_q(period),
    .done_q(period_done)
  );
  // Events: input edges per selected edge, wire break, cycle end, period done
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_edge
      assign edge_ev[g] = hw_d[g] & (fall_d[g] ? (pin_prev_q[g] & ~pin_s2_q[g])
        : (~pin_prev_q[g] & pin_s2_q[g])); // RQ6
    end
  endgenerate
  assign ev = {period_done, AI_CYCLE_DONE & (|eoc_d),
    (|(AI_WIRE_BREAK & wbrk_d)) & mirq_q[0], 1'b0, edge_ev}; // RQ2
  wire stat_rd = RD && ADDR == `IOP_A_STAT;
  // Status: set wins over read-clear
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      stat_q <= `IOP_ZERO8;
      mask_q <= `IOP_ZERO8;
    end else begin
      stat_q <= (stat_rd ? `IOP_ZERO8 : stat_q) | ev;
      if (WR && ADDR == `IOP_A_MASK) mask_q <= WDATA;
    end
  end
  // Read mux, unmapped reads zero
  always @* begin
    case (ADDR)
      `IOP_A_DIAG: rd_d = diag_q;
      `IOP_A_WBRK: rd_d = wbrk_q;
      `IOP_A_RSV: rd_d = `IOP_ZERO8; // RQ16
      `IOP_A_MIRQ: rd_d = mirq_q;
      `IOP_A_UI0: rd_d = ui_q[0];
      `IOP_A_UI1: rd_d = ui_q[1];
      `IOP_A_UI2: rd_d = ui_q[2];
      `IOP_A_UI3: rd_d = ui_q[3];
      `IOP_A_SCAN: rd_d = scan_q;
      `IOP_A_AI0: rd_d = ai_q[0];
      `IOP_A_AI1: rd_d = ai_q[1];
      `IOP_A_AI2: rd_d = ai_q[2];
      `IOP_A_STAT: rd_d = stat_q;
      `IOP_A_MASK: rd_d = mask_q;
      `IOP_A_PLO: rd_d = period[7:0];
      `IOP_A_PMID: rd_d = period[15:8];
      `IOP_A_PHI: rd_d = period[23:16];
      default: rd_d = `IOP_ZERO8;
    endcase
  end
  // Registered outputs
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      RDATA <= 8'h00;
      DIAG_EN <= 4'h0;
      WBRK_ACTIVE <= 4'h0;
      AO_DIAG_EN <= 1'b0;
      MOD_DIAG_IRQ_EN <= 1'b0;
      UI_USE <= 12'h000;
      UI_HW_IRQ <= 4'h0;
      UI_FALLING <= 4'h0;
      UI_COUNT_DOWN <= 3'h0;
      UI3_GATE <= `IOP_GATE_OFF;
      UI3_FREQ_MODE <= 1'b0;
      UI3_PERIOD_MODE <= 1'b0;
      SCAN_SEL <= 2'h0;
      AI_MEAS <= 9'h049;
      AI_RANGE <= 12'h999;
      AI_EOC_IRQ <= 3'h0;
      IRQ <= 1'b0;
    end else begin
      RDATA <= RD ? rd_d : 8'h00;
      DIAG_EN <= diag_q[3:0];
      WBRK_ACTIVE <= wbrk_d; // RQ1
      AO_DIAG_EN <= diag_q[4];
      MOD_DIAG_IRQ_EN <= mirq_q[0]; // RQ2
      UI_USE <= {use_dec[3], use_dec[2], use_dec[1], use_dec[0]};
      UI_HW_IRQ <= hw_d;
      UI_FALLING <= fall_d;
      UI_COUNT_DOWN <= dir_d;
      UI3_GATE <= gate_d;
      UI3_FREQ_MODE <= use_dec[2] == `IOP_USE_FC; // RQ4
      UI3_PERIOD_MODE <= use_dec[2] == `IOP_USE_PER;
      SCAN_SEL <= scan_sel_d; // RQ11
      AI_MEAS <= meas_d;
      AI_RANGE <= rng_d;
      AI_EOC_IRQ <= eoc_d;
      IRQ <= |(((stat_rd ? `IOP_ZERO8 : stat_q) | ev) & mask_q);
    end
  end
endmodule
`default_nettype wire

// >>> inc/iop_defs.vh
// Purpose: Constants for the I/O parameter block
// Assumes: Plain register port, byte registers, 25 MHz clock
// Notes: Summary of operation
// Summary of operation
// RQ1: Wire-break enables, only on 4..20 mA range
// RQ2: Module diagnostic interrupt enable bit
// RQ3: Inputs one, two: binary, interrupt, counter
// RQ4: Input three adds frequency and period modes
// RQ5: Input four: binary or interrupt only
// RQ6: Hardware interrupt forced or selectable
// RQ7: Edge bit: zero rising, one falling
// RQ8: Input three edge only for codes one, two
// RQ9: Direction bit effective only as counter
// RQ10: Gate time 0.1 s, 1 s, 10 s
// RQ11: Scan cycle code selects conversion period
// RQ12: Analog byte: measurement type and range
// RQ13: End-of-cycle interrupt not when continuous
// RQ14: Software checks parameter consistency when running
// RQ15: Period counter 0.5 us ticks, saturating 24 bit; code ticks every 13 cycles, 0.52 us
// RQ16: Reserved reads zero, bad codes deactivate
// RQ17: Reset loads defaults: voltage, 10 V, binary
`ifndef IOP_DEFS_VH
`define IOP_DEFS_VH
`define IOP_SET_BIT 4
`define IOP_A_DIAG 5'h00
`define IOP_A_WBRK 5'h01
`define IOP_A_RSV 5'h02
`define IOP_A_MIRQ 5'h03
`define IOP_A_UI0 5'h10
`define IOP_A_UI1 5'h11
`define IOP_A_UI2 5'h12
`define IOP_A_UI3 5'h13
`define IOP_A_SCAN 5'h14
`define IOP_A_AI0 5'h15
`define IOP_A_AI1 5'h16
`define IOP_A_AI2 5'h17
`define IOP_A_STAT 5'h18
`define IOP_A_MASK 5'h19
`define IOP_A_PLO 5'h1A
`define IOP_A_PMID 5'h1B
`define IOP_A_PHI 5'h1C
`define IOP_DIAG_MASK 8'h1F
`define IOP_WBRK_MASK 8'h0F
`define IOP_MIRQ_MASK 8'h01
`define IOP_UI_MASK 8'hFF
`define IOP_UI12_MASK 8'h3F
`define IOP_UI3_MASK 8'h1F
`define IOP_AI_MASK 8'hF7
`define IOP_AI_RESET 8'h91
`define IOP_ZERO8 8'h00
`define IOP_USE_DI 3'h0
`define IOP_USE_IRQ 3'h1
`define IOP_USE_CI 3'h2
`define IOP_USE_FC 3'h3
`define IOP_USE_PER 3'h4
`define IOP_TYPE_OFF 2'h0
`define IOP_TYPE_V 2'h1
`define IOP_TYPE_I 2'h2
`define IOP_RNG_OFF 4'h0
`define IOP_RNG_420 4'h3
`define IOP_RNG_PM20 4'h4
`define IOP_RNG_PM10 4'h9
`define IOP_SCAN_16 8'h00
`define IOP_SCAN_CONT 8'h01
`define IOP_SCAN_3 8'h06
`define IOP_SCAN_35 8'h07
`define IOP_SCAN_4 8'h08
`define IOP_GATE_01 2'h0
`define IOP_GATE_1 2'h1
`define IOP_GATE_10 2'h2
`define IOP_GATE_OFF 2'h3
`define IOP_CLK_NS 40
`define IOP_TICK_PS 500000
`define IOP_TICK_CYC 5'h0C
`define IOP_CNT_MAX 24'hFFFFFF
`define IOP_CNT_ONE 24'h000001
`endif

// >>> rtl/iop_period_counter.v
// Purpose: Period time counter for universal input three
// Assumes: Synchronised input level and one-cycle tick enable
// Notes: Saturates at all ones to flag underrange
`timescale 1ns/1ps
`default_nettype none
`include "iop_defs.vh"
module iop_period_counter (
  input wire clk,
  input wire rst,
  input wire enable,
  input wire tick,
  input wire level,
  output reg [23:0] period_q,
  output reg done_q
);
  reg prev_q;
  reg armed_q;
  reg [23:0] cnt_q;
  wire rise = level & ~prev_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b0;
      armed_q <= 1'b0;
      cnt_q <= 24'h000000;
      period_q <= 24'h000000;
      done_q <= 1'b0;
    end else begin
      prev_q <= level;
      done_q <= 1'b0;
      if (!enable) begin
        armed_q <= 1'b0;
        cnt_q <= 24'h000000;
      end else if (rise) begin
        armed_q <= 1'b1;
        cnt_q <= 24'h000000;
        if (armed_q) begin
          period_q <= cnt_q; // RQ15
          done_q <= 1'b1;
        end
      end else if (armed_q && tick && cnt_q != `IOP_CNT_MAX) begin
        cnt_q <= cnt_q + `IOP_CNT_ONE; // RQ15
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/iop_param_block_properties.sv
// Purpose: Port assertions for the I/O parameter block
// Assumes: One clock, asynchronous active-high reset
// Notes: Bound to every instance of the parameter block
`timescale 1ns/1ps
`default_nettype none
`include "iop_defs.vh"
module iop_param_block_chk (
  input wire CLK_SYS,
  input wire RST,
  input wire [4:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] RDATA,
  input wire [3:0] WBRK_ACTIVE,
  input wire MOD_DIAG_IRQ_EN,
  input wire [11:0] UI_USE,
  input wire [3:0] UI_HW_IRQ,
  input wire [3:0] UI_FALLING,
  input wire [2:0] UI_COUNT_DOWN,
  input wire UI3_FREQ_MODE,
  input wire [1:0] SCAN_SEL,
  input wire [11:0] AI_RANGE,
  input wire [2:0] AI_EOC_IRQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  chk_rsvd_reads_zero: assert property (
    RD && ADDR == `IOP_A_RSV |=> RDATA == 8'h00) else $error("Reserved byte read not zero");
  chk_irq_en_write: assert property (
    WR && ADDR == `IOP_A_MIRQ |-> ##2 {7'h00, MOD_DIAG_IRQ_EN} == ($past(WDATA, 2) & 8'h01))
    else $error("Module interrupt enable does not follow write");
  chk_wbrk_range: assert property (
    WBRK_ACTIVE[0] |-> AI_RANGE[3:0] == 4'h3) else $error("Wire break active off current range");
  chk_use_one_two: assert property (
    UI_USE[2:0] <= 3'h2 && UI_USE[5:3] <= 3'h2) else $error("Input one or two use out of range");
  chk_use_four: assert property (
    UI_USE[11:9] <= 3'h1) else $error("Input four use has a counting mode");
  chk_hw_forced: assert property (
    UI_USE[2:0] == 3'h1 |-> UI_HW_IRQ[0]) else $error("Interrupt input without hw interrupt");
  chk_dir_counter: assert property (
    UI_COUNT_DOWN[0] |-> UI_USE[2:0] == 3'h2) else $error("Down count outside counter use");
  chk_edge_three: assert property (
    UI_FALLING[2] |-> UI_USE[8:6] inside {3'h1, 3'h2}) else $error("Input three edge misapplied");
  chk_freq_decode: assert property (
    UI3_FREQ_MODE == (UI_USE[8:6] == 3'h3)) else $error("Frequency mode decode wrong");
  chk_eoc_not_cont: assert property (
    AI_EOC_IRQ != 3'h0 |-> SCAN_SEL != 2'h1) else $error("End of cycle irq with continuous scan");
  cover property (WR && ADDR == `IOP_A_MIRQ);
  cover property (UI3_FREQ_MODE);
  cover property (AI_EOC_IRQ != 3'h0);
endmodule
bind iop_param_block iop_param_block_chk u_chk (.CLK_SYS, .RST, .ADDR, .WDATA, .WR, .RD,
  .RDATA, .WBRK_ACTIVE, .MOD_DIAG_IRQ_EN, .UI_USE, .UI_HW_IRQ, .UI_FALLING, .UI_COUNT_DOWN,
  .UI3_FREQ_MODE, .SCAN_SEL, .AI_RANGE, .AI_EOC_IRQ);
`default_nettype wire

// >>> sim/tb_iop_param_block.sv
// Purpose: Self-checking bench for the I/O parameter block
// Assumes: Plain register port, read data one cycle after strobe
// Notes: Wire-break and cycle-end inputs pulsed by the bench
`timescale 1ns/1ps
`default_nettype none
`include "iop_defs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb_iop_param_block;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic [4:0] ADDR = 5'h00;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [3:0] UI_PIN = 4'h0;
  logic AI_CYCLE_DONE = 1'b0;
  logic [3:0] AI_WIRE_BREAK = 4'h0;
  wire [7:0] RDATA;
  wire [3:0] DIAG_EN, WBRK_ACTIVE, UI_HW_IRQ, UI_FALLING;
  wire AO_DIAG_EN, MOD_DIAG_IRQ_EN, UI3_FREQ_MODE, UI3_PERIOD_MODE, IRQ;
  wire [11:0] UI_USE, AI_RANGE;
  wire [2:0] UI_COUNT_DOWN, AI_EOC_IRQ;
  wire [1:0] UI3_GATE, SCAN_SEL;
  wire [8:0] AI_MEAS;
  logic [7:0] got;
  int mismatches = 0;
  int tests_run = 0;
  int i;
  logic [4:0] ra [7] = '{`IOP_A_DIAG, `IOP_A_WBRK, `IOP_A_RSV, `IOP_A_MIRQ, 5'h1D,
    `IOP_A_UI0, `IOP_A_UI3};
  logic [7:0] rm [7] = '{8'h1F, 8'h0F, 8'h00, 8'h01, 8'h00, 8'h3F, 8'h1F};
  logic [7:0] ad [4] = '{8'h91, 8'h32, 8'h42, 8'h00};
  logic [3:0] er [4] = '{4'h9, 4'h3, 4'h4, 4'h0};
  logic [2:0] em [4] = '{3'h1, 3'h2, 3'h2, 3'h0};
  logic [4:0] ba [14] = '{5'h10, 5'h10, 5'h10, 5'h10, 5'h10, 5'h10, 5'h10, 5'h10,
    5'h12, 5'h12, 5'h12, 5'h12, 5'h12, 5'h12};
  logic [7:0] bd [14] = '{8'h01, 8'h02, 8'h0A, 8'h08, 8'h10, 8'h11, 8'h22, 8'h21,
    8'h13, 8'h12, 8'h22, 8'h43, 8'h83, 8'hC3};
  logic [6:0] be [14] = '{7'h43, 7'h03, 7'h43, 7'h03, 7'h03, 7'h63, 7'h13, 7'h43,
    7'h40, 7'h4B, 7'h47, 7'h41, 7'h42, 7'h43};
  logic [7:0] sd [7] = '{8'h00, 8'h01, 8'h06, 8'h07, 8'h08, 8'h02, 8'h09};
  logic [1:0] se [7] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h0, 2'h0};
  iop_param_block u_dut (.CLK_SYS, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .UI_PIN,
    .AI_WIRE_BREAK, .AI_CYCLE_DONE, .DIAG_EN, .WBRK_ACTIVE, .AO_DIAG_EN,
    .MOD_DIAG_IRQ_EN, .UI_USE, .UI_HW_IRQ, .UI_FALLING, .UI_COUNT_DOWN, .UI3_GATE,
    .UI3_FREQ_MODE, .UI3_PERIOD_MODE, .SCAN_SEL, .AI_MEAS, .AI_RANGE, .AI_EOC_IRQ, .IRQ);
  initial forever #20 CLK_SYS = ~CLK_SYS;
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask
  task automatic setw(input logic [4:0] a, input logic [7:0] d);
    wr(a, d);
    repeat (2) @(posedge CLK_SYS);
    #1;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    #1 got = RDATA;
  endtask
  task automatic pulse(input logic wb);
    @(posedge CLK_SYS);
    if (wb) AI_WIRE_BREAK <= 4'h1;
    else AI_CYCLE_DONE <= 1'b1;
    @(posedge CLK_SYS);
    AI_WIRE_BREAK <= 4'h0;
    AI_CYCLE_DONE <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    #1;
  endtask
  task automatic conclude;
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge CLK_SYS);
    mismatches++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge CLK_SYS);
    `CHK({AI_MEAS, AI_RANGE, UI_USE}, {9'h049, 12'h999, 12'h000})
    RST <= 1'b0;
    rd(`IOP_A_AI2);
    `CHK(got, `IOP_AI_RESET)
    for (i = 0; i < 7; i++) begin
      wr(ra[i], 8'hFF);
      rd(ra[i]);
      `CHK(got, rm[i])
    end
    `CHK({DIAG_EN, AO_DIAG_EN, MOD_DIAG_IRQ_EN, WBRK_ACTIVE}, 10'h3F0)
    setw(`IOP_A_AI0, 8'h32);
    `CHK(WBRK_ACTIVE, 4'h1)
    setw(`IOP_A_MIRQ, 8'h00);
    `CHK(MOD_DIAG_IRQ_EN, 1'b0)
    for (i = 0; i < 4; i++) begin
      setw(`IOP_A_AI1, ad[i]);
      `CHK({AI_RANGE[7:4], AI_MEAS[5:3]}, {er[i], em[i]})
    end
    setw(`IOP_A_AI1, 8'h51);
    `CHK(AI_RANGE[7:4], 4'h0)
    for (i = 0; i < 8; i++) begin
      wr(`IOP_A_UI0, 8'(i));
      wr(`IOP_A_UI2, 8'(i));
      setw(`IOP_A_UI3, 8'(i));
      `CHK(UI_USE[2:0], (i < 3) ? 3'(i) : 3'h0)
      `CHK(UI_USE[8:6], (i < 5) ? 3'(i) : 3'h0)
      `CHK(UI_USE[11:9], (i < 2) ? 3'(i) : 3'h0)
      `CHK({UI3_FREQ_MODE, UI3_PERIOD_MODE}, {i == 3, i == 4})
    end
    for (i = 0; i < 14; i++) begin
      setw(ba[i], bd[i]);
      `CHK({UI_HW_IRQ[0], UI_FALLING[0], UI_COUNT_DOWN[0], UI_FALLING[2], UI_COUNT_DOWN[2],
        UI3_GATE}, be[i])
    end
    for (i = 0; i < 7; i++) begin
      setw(`IOP_A_SCAN, sd[i]);
      `CHK(SCAN_SEL, se[i])
    end
    setw(`IOP_A_SCAN, `IOP_SCAN_CONT);
    setw(`IOP_A_AI0, 8'h95);
    `CHK(AI_EOC_IRQ[0], 1'b0)
    setw(`IOP_A_SCAN, `IOP_SCAN_16);
    `CHK(AI_EOC_IRQ[0], 1'b1)
    setw(`IOP_A_MASK, 8'h40);
    pulse(1'b0);
    `CHK(IRQ, 1'b1)
    rd(`IOP_A_STAT);
    `CHK(got, 8'h40)
    @(posedge CLK_SYS);
    #1;
    `CHK(IRQ, 1'b0)
    setw(`IOP_A_MASK, 8'h00);
    pulse(1'b0);
    `CHK(IRQ, 1'b0)
    rd(`IOP_A_STAT);
    `CHK(got, 8'h40)
    @(posedge CLK_SYS);
    UI_PIN <= 4'h1;
    repeat (6) @(posedge CLK_SYS);
    rd(`IOP_A_STAT);
    `CHK(got, 8'h01)
    wr(`IOP_A_UI2, 8'h04);
    for (i = 0; i < 2; i++) begin
      UI_PIN <= 4'h5;
      repeat (65) @(posedge CLK_SYS);
      UI_PIN <= 4'h1;
      repeat (65) @(posedge CLK_SYS);
    end
    `CHK(UI3_PERIOD_MODE, 1'b1)
    rd(`IOP_A_PLO);
    `CHK(got inside {8'h09, 8'h0A}, 1'b1)
    rd(`IOP_A_PMID);
    `CHK(got, 8'h00)
    rd(`IOP_A_PHI);
    `CHK(got, 8'h00)
    rd(`IOP_A_STAT);
    `CHK(got, 8'h80)
    setw(`IOP_A_AI0, 8'h32);
    setw(`IOP_A_MIRQ, 8'h01);
    pulse(1'b1);
    rd(`IOP_A_STAT);
    `CHK(got, 8'h20)
    setw(`IOP_A_MIRQ, 8'h00);
    pulse(1'b1);
    rd(`IOP_A_STAT);
    `CHK(got, 8'h00)
    conclude();
  end
endmodule
`default_nettype wire
